// ==== common/intc_pkg.sv ====
package intc_pkg;
	// register byte addresses on the wishbone bus
	localparam logic [4:0] adr_trap_status_control        = 5'h00;
	localparam logic [4:0] adr_global_vector_edge_control = 5'h04;
	localparam logic [4:0] adr_request_flags_0            = 5'h08;
	localparam logic [4:0] adr_request_flags_1            = 5'h0c;
	localparam logic [4:0] adr_request_flags_4            = 5'h10;
	localparam logic [4:0] adr_request_enables_0          = 5'h14;
	localparam logic [4:0] adr_request_enables_1          = 5'h18;
	localparam logic [4:0] adr_priority_0                 = 5'h1c;
	// trap register fields
	localparam int pos_stack_trap    = 2;
	localparam int pos_osc_fail_trap = 1;
	localparam logic [15:0] trap_mask = 16'h0006;
	// global control fields
	localparam int pos_alt_vector    = 15;
	localparam int pos_disable_insn  = 14;
	localparam logic [15:0] gctl_wr_mask = 16'h8007;
	// implemented bits of flag and enable registers
	localparam logic [15:0] impl_mask_0 = 16'h3fef;
	localparam logic [15:0] impl_mask_1 = 16'h20db;
	localparam logic [15:0] impl_mask_4 = 16'h0002;
	// priority register: ext0 in [2:0], capture1 in [6:4]
	localparam logic [15:0] prio_mask  = 16'h0077;
	localparam logic [15:0] prio_reset = 16'h0044;
	localparam int pos_ext0     = 0;
	localparam int pos_capture1 = 1;
	localparam int num_ext      = 3;
	localparam int sync_stages  = 2;
	// external interrupt bit positions in flag registers
	localparam int pos_ext1_flag = 4;
	localparam int pos_ext2_flag = 13;
	localparam logic [4:0] reset_zero5 = 5'h00;
endpackage

// ==== rtl/intc_edge_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module intc_edge_sync #(
	parameter int width = 3
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// pins and polarity
	input  wire logic [width-1:0] pin,
	input  wire logic [width-1:0] falling,
	// detected edges
	output logic      [width-1:0] edge_seen
);
	typedef struct packed {
		logic [width-1:0] s1;
		logic [width-1:0] s2;
		logic [width-1:0] prev;
		logic [2:0]       live;
	} sync_t;
	sync_t st;
	sync_t next_st;

	// two-stage synchroniser then edge compare on second stage only
	always_comb begin
		next_st      = st;
		next_st.s1   = pin;
		next_st.s2   = st.s1;
		next_st.prev = st.s2;
		next_st.live = {st.live[1:0], 1'b1};
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// falling when polarity bit is 1, rising when 0
	// held off until the pipe holds real pin samples, so a pin idling high
	// gives no false rising edge after reset
	assign edge_seen = {width{st.live[2]}}
		& ((falling & st.prev & ~st.s2) | (~falling & ~st.prev & st.s2));
endmodule
`default_nettype wire

// ==== rtl/interrupt_flag_enable_regs.sv ====
// What this block does
// - stack-error trap bit 2 sets on a stack trap, zero otherwise
// - oscillator-failure trap bit 1 sets on that trap, zero otherwise
// - trap register bit 0 is unimplemented and reads zero
// - three edge polarity bits: 0 rising edge, 1 falling edge
// - each flag reads 1 after its request until cleared
// - capture channel 1 flag lives in flags register 0 bit 1
// - external interrupt 0 flag lives in flags register 0 bit 0
// - enable bit 1 lets a request through, 0 blocks it
// - capture channel 1 enable lives in enables register 0 bit 1
// - external interrupt 0 enable lives in enables register 0 bit 0
// - hardware sets flags, only software writes clear them
// - alternate vector bit selects standard or alternate vector table
// - priority zero disables a source regardless of flag and enable
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module interrupt_flag_enable_regs
	import intc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// trap events from the core, one-cycle pulses
	input  wire logic        stack_trap_event,
	input  wire logic        osc_fail_trap_event,
	// core status
	input  wire logic        disable_insn_active,
	// external interrupt pins, asynchronous
	input  wire logic [2:0]  ext_pin,
	// peripheral request pulses, same clock
	input  wire logic [15:0] periph_req_0,
	input  wire logic [15:0] periph_req_1,
	input  wire logic [15:0] periph_req_4,
	// to the cpu
	output logic             alt_vector_select,
	output logic             pending_ext0,
	output logic             pending_capture1,
	output logic             irq
);
	typedef struct packed {
		logic [15:0] trap;
		logic [15:0] gctl;
		logic [15:0] flags_0;
		logic [15:0] flags_1;
		logic [15:0] flags_4;
		logic [15:0] enables_0;
		logic [15:0] enables_1;
		logic [15:0] prio;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
		logic        alt;
		logic        pend_e0;
		logic        pend_c1;
		logic        irq;
	} state_t;
	state_t st;
	state_t next_st;

	logic [2:0]  ext_edge;
	logic [15:0] set_0;
	logic [15:0] set_1;
	logic [15:0] set_4;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [15:0] any_pend_0;
	logic [15:0] any_pend_1;

	// byte-lane merge of a 16-bit register under a writable mask
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] sel, input logic [15:0] wmask);
		logic [15:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = d[7:0];
		end
		if (sel[1]) begin
			v[15:8] = d[15:8];
		end
		return (v & wmask) | (old & ~wmask);
	endfunction

	// flag update: software writes may clear, hardware set wins
	function automatic logic [15:0] flag_next(input logic [15:0] old, input logic [15:0] set,
			input logic do_wr, input logic [31:0] d, input logic [3:0] sel,
			input logic [15:0] impl);
		logic [15:0] v;
		v = do_wr ? merge(old, d, sel, impl) : old;
		return (v | set) & impl;
	endfunction

	// write strobe aimed at one register address
	function automatic logic wr_at(input logic do_wr, input logic [4:0] a, input logic [4:0] target);
		return do_wr && (a == target);
	endfunction

	// pending test for one source with a three-bit priority field
	function automatic logic prio_pend(input logic flag_en, input logic [2:0] level);
		return flag_en && (level != 3'h0);
	endfunction

	// external pins synchronised and edge-detected per polarity
	intc_edge_sync #(
		.width(num_ext)
	) u_edge (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.pin      (ext_pin),
		.falling  (st.gctl[num_ext-1:0]),
		.edge_seen(ext_edge)
	);

	// hardware set sources
	always_comb begin
		set_0 = periph_req_0;
		set_1 = periph_req_1;
		set_4 = periph_req_4;
		set_0[pos_ext0]      = periph_req_0[pos_ext0] | ext_edge[0];
		set_1[pos_ext1_flag] = periph_req_1[pos_ext1_flag] | ext_edge[1];
		set_1[pos_ext2_flag] = periph_req_1[pos_ext2_flag] | ext_edge[2];
	end

	assign hit = (wb_adr_i <= adr_priority_0) && (wb_adr_i[1:0] == 2'b00);
	assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !st.ack && !st.err && hit;
	assign rd  = wb_cyc_i && wb_stb_i && !wb_we_i && !st.ack && !st.err && hit;

	// pending terms for every source in registers 0 and 1
	assign any_pend_0 = st.flags_0 & st.enables_0;
	assign any_pend_1 = st.flags_1 & st.enables_1;

	// next state: bus answer, register updates, read data and cpu-side outputs
	always_comb begin
		next_st = st;

		// bus answer: exactly one of ack or err for each new request;
		// never two in a row, so a request still held is not answered twice
		next_st.ack = wb_cyc_i && wb_stb_i && !st.ack && !st.err && hit;
		next_st.err = wb_cyc_i && wb_stb_i && !st.ack && !st.err && !hit;

		// read data stays zero outside an ack cycle
		next_st.rdata = '0;

		// trap bits: write may clear, event sets and wins;
		// otherwise a clear landing with a trap would lose the trap
		if (wr_at(wr, wb_adr_i, adr_trap_status_control)) begin
			next_st.trap = merge(st.trap, wb_dat_i, wb_sel_i, trap_mask);
		end

		// hardware trap events
		next_st.trap[pos_stack_trap]    = next_st.trap[pos_stack_trap] | stack_trap_event;
		next_st.trap[pos_osc_fail_trap] = next_st.trap[pos_osc_fail_trap] | osc_fail_trap_event;

		// unimplemented trap positions never hold a one
		next_st.trap = next_st.trap & trap_mask;

		// global control: vector select and edge polarities are writable;
		// disable status only follows the core and ignores writes
		if (wr_at(wr, wb_adr_i, adr_global_vector_edge_control)) begin
			next_st.gctl = merge(st.gctl, wb_dat_i, wb_sel_i, gctl_wr_mask);
		end
		next_st.gctl[pos_disable_insn] = disable_insn_active;

		// flag registers: hardware set, software write stores its value;
		// a set in the same cycle as a clearing write survives
		next_st.flags_0 = flag_next(st.flags_0, set_0, wr_at(wr, wb_adr_i, adr_request_flags_0),
			wb_dat_i, wb_sel_i, impl_mask_0);

		// second flag register carries ext1 and ext2 among others
		next_st.flags_1 = flag_next(st.flags_1, set_1, wr_at(wr, wb_adr_i, adr_request_flags_1),
			wb_dat_i, wb_sel_i, impl_mask_1);

		// fifth flag register has a single implemented source
		next_st.flags_4 = flag_next(st.flags_4, set_4, wr_at(wr, wb_adr_i, adr_request_flags_4),
			wb_dat_i, wb_sel_i, impl_mask_4);

		// enable registers: plain storage under the implemented mask
		if (wr_at(wr, wb_adr_i, adr_request_enables_0)) begin
			next_st.enables_0 = merge(st.enables_0, wb_dat_i, wb_sel_i, impl_mask_0);
		end
		if (wr_at(wr, wb_adr_i, adr_request_enables_1)) begin
			next_st.enables_1 = merge(st.enables_1, wb_dat_i, wb_sel_i, impl_mask_1);
		end

		// priority fields of ext0 and capture1; other positions stay zero
		if (wr_at(wr, wb_adr_i, adr_priority_0)) begin
			next_st.prio = merge(st.prio, wb_dat_i, wb_sel_i, prio_mask);
		end

		// read mux: only aligned mapped addresses reach here,
		// so the default is for safety only
		if (rd) begin
			unique case (wb_adr_i)
				adr_trap_status_control:        next_st.rdata = {16'h0000, st.trap & trap_mask};
				adr_global_vector_edge_control: next_st.rdata = {16'h0000, st.gctl};
				adr_request_flags_0:            next_st.rdata = {16'h0000, st.flags_0};
				adr_request_flags_1:            next_st.rdata = {16'h0000, st.flags_1};
				adr_request_flags_4:            next_st.rdata = {16'h0000, st.flags_4};
				adr_request_enables_0:          next_st.rdata = {16'h0000, st.enables_0};
				adr_request_enables_1:          next_st.rdata = {16'h0000, st.enables_1};
				adr_priority_0:                 next_st.rdata = {16'h0000, st.prio};
				default:                        next_st.rdata = '0;
			endcase
		end

		// vector table select toward the core, one cycle behind the register
		next_st.alt = st.gctl[pos_alt_vector];

		// pending with priority gating: a zero level disables the source
		// even when its flag and enable are both set
		next_st.pend_e0 = prio_pend(any_pend_0[pos_ext0], st.prio[2:0]);
		next_st.pend_c1 = prio_pend(any_pend_0[pos_capture1], st.prio[6:4]);

		// one level request toward the core:
		// the two prioritised sources,
		// every other enabled flag of registers 0 and 1,
		// and any trap bit still set
		next_st.irq = next_st.pend_e0
			|| next_st.pend_c1
			|| (|(any_pend_0 & ~16'h0003))
			|| (|any_pend_1)
			|| (|(st.trap & trap_mask));
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st      <= '0;
			st.prio <= prio_reset;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign wb_dat_o          = st.rdata;
	assign wb_ack_o          = st.ack;
	assign wb_err_o          = st.err;
	assign alt_vector_select = st.alt;
	assign pending_ext0      = st.pend_e0;
	assign pending_capture1  = st.pend_c1;
	assign irq               = st.irq;
endmodule
`default_nettype wire

// ==== dv/intc_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module intc_checker
	import intc_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// bus side
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [4:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	// events and cpu side
	input wire logic        stack_trap_event,
	input wire logic        osc_fail_trap_event,
	input wire logic        alt_vector_select,
	input wire logic        pending_ext0,
	input wire logic        pending_capture1,
	input wire logic        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// bus handshake
	one_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
		else $error("missing or double answer");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper half set");
	misalign_err_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i[1:0] != 2'h0
		|=> wb_err_o) else $error("misaligned not refused");
	// register contents seen on reads
	trap_bit0_a: assert property (wb_ack_o && $past(wb_adr_i) == adr_trap_status_control && !$past(wb_we_i)
		|-> !wb_dat_o[0]) else $error("trap bit 0 set");
	flag_unimpl_a: assert property (wb_ack_o && $past(wb_adr_i) == adr_request_flags_0 && !$past(wb_we_i)
		|-> (wb_dat_o[15:0] & ~impl_mask_0) == 16'h0) else $error("unimplemented flag set");
	alt_mirror_a: assert property (wb_ack_o && $past(wb_adr_i) == adr_global_vector_edge_control
		&& !$past(wb_we_i) |-> wb_dat_o[15] == alt_vector_select) else $error("alt select mismatch");
	// traps and pending
	stack_irq_a: assert property (stack_trap_event |-> ##2 irq) else $error("stack trap lost");
	osc_irq_a: assert property (osc_fail_trap_event |-> ##2 irq) else $error("osc trap lost");
	pend_irq_a: assert property (pending_ext0 || pending_capture1 |-> irq) else $error("pending without irq");
endmodule
bind interrupt_flag_enable_regs intc_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .stack_trap_event(stack_trap_event), .osc_fail_trap_event(osc_fail_trap_event),
	.alt_vector_select(alt_vector_select), .pending_ext0(pending_ext0), .pending_capture1(pending_capture1),
	.irq(irq));
`default_nettype wire

// ==== dv/req_source_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module req_source_model (
	// clock and command
	input  wire logic        clk_sys,
	input  wire logic        go,
	input  wire logic [5:0]  pick,
	// request pulses
	output logic             stack_trap_event,
	output logic             osc_fail_trap_event,
	output logic      [15:0] periph_req_0,
	output logic      [15:0] periph_req_1,
	output logic      [15:0] periph_req_4
);
	// one-cycle pulse on the chosen source, low otherwise
	always_ff @(posedge clk_sys) begin
		stack_trap_event <= go && pick == 6'h30;
		osc_fail_trap_event <= go && pick == 6'h31;
		periph_req_0 <= (go && pick[5:4] == 2'h0) ? 16'h1 << pick[3:0] : 16'h0;
		periph_req_1 <= (go && pick[5:4] == 2'h1) ? 16'h1 << pick[3:0] : 16'h0;
		periph_req_4 <= (go && pick[5:4] == 2'h2) ? 16'h1 << pick[3:0] : 16'h0;
	end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
	import intc_pkg::*;
	// drives and observed outputs
	logic        clk_sys = 0, rst_n = 0, req = 0, we = 0, go = 0, dis = 0;
	logic [4:0]  adr = 0;
	logic [31:0] wdat = 0, rdat, dout;
	logic        ack, err, alt, p0, p1, irq, stk, osc, gotr;
	logic [2:0]  pin = 0;
	logic [5:0]  pick = 0;
	logic [3:0]  sel = 4'h3;
	logic [15:0] q0, q1, q4, f, e, pr, x;
	int          bad_count = 0, tests_run = 0, r, b, n;
	logic [15:0] masks[7] = '{16'h0006, 16'h8007, 16'h3fef, 16'h20db, 16'h0002, 16'h3fef, 16'h20db};
	logic [4:0]  fa[3] = '{5'h08, 5'h0c, 5'h0c};
	logic [15:0] fb[3] = '{16'h0001, 16'h0010, 16'h2000};
	always #4 clk_sys = ~clk_sys;
	interrupt_flag_enable_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
		.wb_err_o(err), .stack_trap_event(stk), .osc_fail_trap_event(osc), .disable_insn_active(dis),
		.ext_pin(pin), .periph_req_0(q0), .periph_req_1(q1), .periph_req_4(q4), .alt_vector_select(alt),
		.pending_ext0(p0), .pending_capture1(p1), .irq(irq));
	req_source_model src (.clk_sys(clk_sys), .go(go), .pick(pick), .stack_trap_event(stk),
		.osc_fail_trap_event(osc), .periph_req_0(q0), .periph_req_1(q1), .periph_req_4(q4));
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one classic cycle, held until ack or err
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0, d};
		for (n = 0; n < 20 && !(ack || err); n++) @(posedge clk_sys);
		if (n == 20) begin
			bad_count++;
			print_verdict();
		end
		rdat = dout;
		gotr = err;
		req <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0);
		cmp(rdat, {16'h0, exp});
	endtask
	task automatic fire(input logic [5:0] p);
		@(posedge clk_sys);
		go <= 1'b1;
		pick <= p;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	initial begin
		void'($urandom(32'ha7f3));
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		// reset values, writable bits, clearing
		rd(adr_priority_0, prio_reset);
		for (int i = 0; i < 7; i++) begin
			rd(5'(i * 4), 16'h0);
			wr(5'(i * 4), 16'hffff);
			rd(5'(i * 4), masks[i]);
			if (i == 1) cmp({31'h0, alt}, 32'h1);
			wr(5'(i * 4), 16'h0);
			rd(5'(i * 4), 16'h0);
		end
		dis <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(adr_global_vector_edge_control, 16'h4000);
		dis <= 1'b0;
		bus(1'b0, 5'h02, 16'h0);
		cmp({31'h0, gotr}, 32'h1);
		sel <= 4'h2;
		wr(adr_request_enables_0, 16'hffff);
		sel <= 4'h3;
		rd(adr_request_enables_0, 16'h3f00);
		wr(adr_request_enables_0, 16'h0);
		$display("test registers done");
		// hardware request sources
		fire(6'h30);
		rd(adr_trap_status_control, 16'h0004);
		fire(6'h31);
		rd(adr_trap_status_control, 16'h0006);
		wr(adr_trap_status_control, 16'h0);
		fire(6'h01);
		rd(adr_request_flags_0, 16'h0002);
		wr(adr_request_flags_0, 16'h0);
		for (int k = 0; k < 12; k++) begin
			r = $urandom_range(2);
			b = $urandom_range(15);
			fire(6'(r * 16 + b));
			x = masks[r + 2] & (16'h1 << b);
			rd(5'(8 + r * 4), x);
			wr(5'(8 + r * 4), 16'h0);
		end
		$display("test sources done");
		// edge polarity on each external pin
		for (int i = 0; i < 3; i++) begin
			for (int p = 0; p < 2; p++) begin
				wr(adr_global_vector_edge_control, 16'(p << i));
				pin[i] <= p[0];
				repeat (6) @(posedge clk_sys);
				wr(fa[i], 16'h0);
				pin[i] <= ~p[0];
				repeat (6) @(posedge clk_sys);
				rd(fa[i], fb[i]);
				wr(fa[i], 16'h0);
				pin[i] <= p[0];
				repeat (6) @(posedge clk_sys);
				rd(fa[i], 16'h0);
			end
		end
		$display("test edges done");
		// pending outputs against flag, enable and priority
		for (int k = 0; k < 16; k++) begin
			f = 16'($urandom_range(3));
			e = 16'($urandom_range(3));
			pr = 16'($urandom) & prio_mask;
			wr(adr_request_flags_0, f);
			wr(adr_request_enables_0, e);
			wr(adr_priority_0, pr);
			repeat (2) @(posedge clk_sys);
			x = {14'h0, f[1] & e[1] & (|pr[6:4]), f[0] & e[0] & (|pr[2:0])};
			cmp({30'h0, p1, p0}, {16'h0, x});
			cmp({31'h0, irq}, {31'h0, |x});
		end
		$display("test pending done");
		print_verdict();
	end
endmodule
`default_nettype wire
